// *** common/clock_output_control_defines.vh ***
// register offsets, field positions, reset values and timing for the output control block
`ifndef CLOCK_OUTPUT_CONTROL_DEFINES_VH
`define CLOCK_OUTPUT_CONTROL_DEFINES_VH

`define OFS_OUTPUT_ENABLE 8'h05
`define OFS_MODE_REF 8'h06
`define OFS_IDENT 8'h07

`define OUTPUT_ENABLE_RESET 8'hDF
`define MODE_REF_RESET 8'h03
`define MODE_REF_WRITE_MASK 8'hB7

`define BIT_DOT_CLOCK_EN 7
`define BIT_CPU_PAIR3_EN 6
`define BIT_SHARED_MODE 5
`define BIT_SHARED_EN 4
`define BIT_FIXED_66_EN_HI 3

`define BIT_TEST_CLOCK 7
`define BIT_FS_TEST 5
`define BIT_SRC_200 4
`define BIT_SPREAD 2
`define BIT_REF1_EN 1
`define BIT_REF0_EN 0

`define SMB_ADDRESS_DEFAULT 7'h50
`define REVISION_CODE_DEFAULT 4'h2
`define VENDOR_CODE_DEFAULT 4'h5

`define CLOCK_PERIOD_NS 10
`define RESTART_MAX_NS 1800000
`define CPU_DRIVE_MAX_NS 300000
`define WAKE_GUARD_CYCLES 4

`endif

// *** hw/power_down_sequencer.v ***
// power-down entry detection and wake sequencing
`timescale 1ns/10ps
`include "clock_output_control_defines.vh"

module power_down_sequencer #(
  parameter integer restart_cycles = `RESTART_MAX_NS / `CLOCK_PERIOD_NS,
  parameter integer cpu_drive_cycles = `CPU_DRIVE_MAX_NS / `CLOCK_PERIOD_NS
) (
  input wire clock,
  input wire rst,
  input wire power_down_level_n,
  input wire cpu_phase,
  output reg hold_others,
  output reg hold_cpu
);
  localparam [2:0] st_run = 3'b001;
  localparam [2:0] st_stop = 3'b010;
  localparam [2:0] st_wake = 3'b100;
  localparam integer all_release = restart_cycles - `WAKE_GUARD_CYCLES;
  localparam integer cpu_release = cpu_drive_cycles - `WAKE_GUARD_CYCLES;

  reg [2:0] state;
  reg [2:0] next_state;
  reg cpu_phase_prev;
  reg low_seen;
  reg [31:0] wake_count;
  wire comp_rise;

  // the complement leg rises where the true phase falls
  assign comp_rise = cpu_phase_prev & ~cpu_phase;

  always @* begin
    next_state = state;
    case (state)
      st_run: begin
        if (comp_rise & ~power_down_level_n & low_seen) next_state = st_stop;
      end
      st_stop: begin
        if (power_down_level_n) next_state = st_wake;
      end
      st_wake: begin
        if (~power_down_level_n) next_state = st_stop;
        else if (wake_count >= all_release) next_state = st_run;
      end
      default: begin
        next_state = st_run;
      end
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      state <= st_run;
      cpu_phase_prev <= 1'b0;
      low_seen <= 1'b0;
      wake_count <= 32'h00000000;
      hold_others <= 1'b0;
      hold_cpu <= 1'b0;
    end else begin
      state <= next_state;
      cpu_phase_prev <= cpu_phase;
      if (state != st_run) low_seen <= 1'b0;
      else if (comp_rise) low_seen <= ~power_down_level_n;
      if (next_state == st_wake) wake_count <= wake_count + 32'h00000001;
      else wake_count <= 32'h00000000;
      hold_others <= (next_state != st_run);
      hold_cpu <= (next_state == st_stop) ||
                  ((next_state == st_wake) && (wake_count < cpu_release));
    end
  end
endmodule // power_down_sequencer

// *** hw/clock_output_control_powerdown.v ***
// serial-bus controlled output gating and power-down handling for a clock synthesizer
`timescale 1ns/10ps
`include "clock_output_control_defines.vh"
// Operation
// - output_enable_ctrl_b bit 7 enables the dot clock 48 MHz output, resets 1.
// - output_enable_ctrl_b bit 6 enables CPU pair three, else both legs tri-state; resets 1.
// - output_enable_ctrl_b bit 5 picks shared output: 0 is 66 MHz, 1 is 48 MHz video.
// - output_enable_ctrl_b bit 4 enables the shared 66/48 MHz output, resets 1.
// - output_enable_ctrl_b bits 3 to 0 enable the four fixed 66 MHz outputs, reset 1.
// - mode_and_ref_ctrl bit 7 puts all output groups into test clock mode, resets 0.
// - mode_and_ref_ctrl bit 5 sets frequency-select pins to test mode for CPU pairs.
// - mode_and_ref_ctrl bit 4 selects serial reference pair 100 or 200 MHz, resets 0.
// - mode_and_ref_ctrl bit 2 turns spread spectrum on, resets 0.
// - mode_and_ref_ctrl bits 1 and 0 enable reference outputs 1 and 0, reset 1.
// - identification_byte reads fixed revision and vendor codes; writes are ignored.
// - power-down low on two complement rises holds non-CPU outputs low at next fall.
// - in power-down CPU true leg driven high at double current, complement undriven.
// - reference outputs may need more than one cycle to stop low.
// - all clocks stop synchronously, with no glitch or short pulse.
// - after power-down release all outputs restart within 1.8 ms.
// - after release CPU outputs are driven within 300 us.
// - per-pair drive-mode bit: 0 keeps pair driven, 1 tri-states it in power-down.

module clock_output_control_powerdown #(
  parameter integer restart_cycles = `RESTART_MAX_NS / `CLOCK_PERIOD_NS,
  parameter integer cpu_drive_cycles = `CPU_DRIVE_MAX_NS / `CLOCK_PERIOD_NS,
  parameter [6:0] smb_address = `SMB_ADDRESS_DEFAULT,
  parameter [3:0] revision_code = `REVISION_CODE_DEFAULT, // arbitrary value
  parameter [3:0] vendor_code = `VENDOR_CODE_DEFAULT // arbitrary value
) (
  input wire clock,
  input wire rst,
  input wire power_down_n,
  input wire smb_clock,
  input wire smb_data_in,
  output reg smb_data_out,
  output reg smb_data_oe,
  input wire ref_phase,
  input wire fixed_66_phase,
  input wire dot_phase,
  input wire video_48_phase,
  input wire cpu_phase,
  input wire [2:0] cpu_low_pairs_enable,
  input wire [3:0] cpu_pd_tristate,
  output reg [1:0] ref_out,
  output reg [3:0] fixed_66_output,
  output reg shared_66_48_output,
  output reg dot_clock_48,
  output reg [3:0] cpu_true_leg,
  output reg [3:0] cpu_true_oe,
  output reg [3:0] cpu_strong_drive,
  output reg [3:0] cpu_complement_leg,
  output reg [3:0] cpu_complement_oe,
  output reg video_clock_48_mode,
  output reg test_clock_mode,
  output reg fs_test_mode,
  output reg serial_reference_pair_200,
  output reg spread_on,
  output reg pll_stopped
);
  localparam [8:0] sm_idle = 9'h001;
  localparam [8:0] sm_addr = 9'h002;
  localparam [8:0] sm_addr_ack = 9'h004;
  localparam [8:0] sm_cmd = 9'h008;
  localparam [8:0] sm_cmd_ack = 9'h010;
  localparam [8:0] sm_wdata = 9'h020;
  localparam [8:0] sm_wdata_ack = 9'h040;
  localparam [8:0] sm_rdata = 9'h080;
  localparam [8:0] sm_rdata_ack = 9'h100;

  reg [7:0] output_enable_ctrl_b;
  reg [7:0] mode_and_ref_ctrl;
  wire [7:0] identification_byte;

  reg pd_sync1;
  reg pd_sync2;
  reg scl_sync1;
  reg scl_sync2;
  reg scl_prev;
  reg sda_sync1;
  reg sda_sync2;
  reg sda_prev;
  reg [8:0] sm_state;
  reg [2:0] bit_count;
  reg [7:0] shift;
  reg byte_done;
  reg read_mode;
  reg [7:0] command;

  reg [1:0] ref_run;
  reg [3:0] fixed_run;
  reg shared_run;
  reg shared_mode_live;
  reg dot_run;
  reg cpu_hold_live;
  reg [3:0] cpu_en_live;
  integer i;

  wire hold_others;
  wire hold_cpu;
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;
  wire write_strobe;
  wire shared_src;
  wire [7:0] read_now;
  wire [7:0] read_next;

  // register readback by command code
  function [7:0] read_byte;
    input [7:0] idx;
    input [7:0] enables;
    input [7:0] modes;
    input [7:0] ident;
    begin
      case (idx)
        `OFS_OUTPUT_ENABLE: read_byte = enables;
        `OFS_MODE_REF: read_byte = modes;
        `OFS_IDENT: read_byte = ident;
        default: read_byte = 8'h00;
      endcase
    end
  endfunction

  assign identification_byte = {revision_code, vendor_code};
  assign read_now = read_byte(command, output_enable_ctrl_b, mode_and_ref_ctrl,
                              identification_byte);
  assign read_next = read_byte(command + 8'h01, output_enable_ctrl_b, mode_and_ref_ctrl,
                               identification_byte);

  assign scl_rise = scl_sync2 & ~scl_prev;
  assign scl_fall = ~scl_sync2 & scl_prev;
  assign bus_start = scl_sync2 & scl_prev & sda_prev & ~sda_sync2;
  assign bus_stop = scl_sync2 & scl_prev & ~sda_prev & sda_sync2;
  assign write_strobe = (sm_state == sm_wdata) & scl_fall & byte_done;
  assign shared_src = shared_mode_live ? video_48_phase : fixed_66_phase;

  power_down_sequencer #(
    .restart_cycles(restart_cycles),
    .cpu_drive_cycles(cpu_drive_cycles)
  ) u_sequencer (
    .clock(clock),
    .rst(rst),
    .power_down_level_n(pd_sync2),
    .cpu_phase(cpu_phase),
    .hold_others(hold_others),
    .hold_cpu(hold_cpu)
  );

  // pin synchronisers
  always @(posedge clock) begin
    if (rst) begin
      pd_sync1 <= 1'b1;
      pd_sync2 <= 1'b1;
      scl_sync1 <= 1'b1;
      scl_sync2 <= 1'b1;
      scl_prev <= 1'b1;
      sda_sync1 <= 1'b1;
      sda_sync2 <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      pd_sync1 <= power_down_n;
      pd_sync2 <= pd_sync1;
      scl_sync1 <= smb_clock;
      scl_sync2 <= scl_sync1;
      scl_prev <= scl_sync2;
      sda_sync1 <= smb_data_in;
      sda_sync2 <= sda_sync1;
      sda_prev <= sda_sync2;
    end
  end

  // serial bus slave: byte write and byte read with auto-increment
  always @(posedge clock) begin
    if (rst) begin
      sm_state <= sm_idle;
      bit_count <= 3'h0;
      shift <= 8'h00;
      byte_done <= 1'b0;
      read_mode <= 1'b0;
      command <= 8'h00;
      smb_data_out <= 1'b0;
      smb_data_oe <= 1'b0;
    end else if (bus_start) begin
      sm_state <= sm_addr;
      bit_count <= 3'h0;
      byte_done <= 1'b0;
      smb_data_oe <= 1'b0;
    end else if (bus_stop) begin
      sm_state <= sm_idle;
      byte_done <= 1'b0;
      smb_data_oe <= 1'b0;
    end else begin
      case (sm_state)
        sm_idle: begin
          smb_data_oe <= 1'b0;
        end
        sm_addr, sm_cmd, sm_wdata: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_sync2};
            bit_count <= bit_count + 3'h1;
            byte_done <= (bit_count == 3'h7);
          end else if (scl_fall & byte_done) begin
            byte_done <= 1'b0;
            if (sm_state == sm_addr) begin
              if (shift[7:1] == smb_address) begin
                sm_state <= sm_addr_ack;
                read_mode <= shift[0];
                smb_data_oe <= 1'b1;
              end else begin
                sm_state <= sm_idle;
              end
            end else if (sm_state == sm_cmd) begin
              command <= shift;
              sm_state <= sm_cmd_ack;
              smb_data_oe <= 1'b1;
            end else begin
              sm_state <= sm_wdata_ack;
              smb_data_oe <= 1'b1;
            end
          end
        end
        sm_addr_ack: begin
          if (scl_fall) begin
            bit_count <= 3'h0;
            if (read_mode) begin
              shift <= read_now;
              smb_data_oe <= ~read_now[7];
              sm_state <= sm_rdata;
            end else begin
              smb_data_oe <= 1'b0;
              sm_state <= sm_cmd;
            end
          end
        end
        sm_cmd_ack: begin
          if (scl_fall) begin
            bit_count <= 3'h0;
            smb_data_oe <= 1'b0;
            sm_state <= sm_wdata;
          end
        end
        sm_wdata_ack: begin
          if (scl_fall) begin
            bit_count <= 3'h0;
            smb_data_oe <= 1'b0;
            command <= command + 8'h01;
            sm_state <= sm_wdata;
          end
        end
        sm_rdata: begin
          if (scl_fall) begin
            if (bit_count == 3'h7) begin
              smb_data_oe <= 1'b0;
              sm_state <= sm_rdata_ack;
            end else begin
              shift <= {shift[6:0], 1'b0};
              smb_data_oe <= ~shift[6];
              bit_count <= bit_count + 3'h1;
            end
          end
        end
        sm_rdata_ack: begin
          if (scl_rise) begin
            if (sda_sync2) sm_state <= sm_idle;
            else byte_done <= 1'b1;
          end else if (scl_fall & byte_done) begin
            byte_done <= 1'b0;
            bit_count <= 3'h0;
            command <= command + 8'h01;
            shift <= read_next;
            smb_data_oe <= ~read_next[7];
            sm_state <= sm_rdata;
          end
        end
        default: begin
          sm_state <= sm_idle;
          smb_data_oe <= 1'b0;
        end
      endcase
    end
  end

  // control registers
  always @(posedge clock) begin
    if (rst) begin
      output_enable_ctrl_b <= `OUTPUT_ENABLE_RESET;
      mode_and_ref_ctrl <= `MODE_REF_RESET;
    end else if (write_strobe) begin
      if (command == `OFS_OUTPUT_ENABLE) output_enable_ctrl_b <= shift;
      else if (command == `OFS_MODE_REF) mode_and_ref_ctrl <= shift & `MODE_REF_WRITE_MASK;
    end
  end

  // mode levels toward the synthesizer core
  always @(posedge clock) begin
    if (rst) begin
      test_clock_mode <= 1'b0;
      fs_test_mode <= 1'b0;
      serial_reference_pair_200 <= 1'b0;
      spread_on <= 1'b0;
      video_clock_48_mode <= 1'b0;
      pll_stopped <= 1'b0;
    end else begin
      test_clock_mode <= mode_and_ref_ctrl[`BIT_TEST_CLOCK];
      fs_test_mode <= mode_and_ref_ctrl[`BIT_FS_TEST];
      serial_reference_pair_200 <= mode_and_ref_ctrl[`BIT_SRC_200];
      spread_on <= mode_and_ref_ctrl[`BIT_SPREAD];
      video_clock_48_mode <= shared_mode_live;
      pll_stopped <= hold_others;
    end
  end

  // single-ended outputs: gates change only while their source is low
  always @(posedge clock) begin
    if (rst) begin
      ref_run <= 2'b00;
      fixed_run <= 4'h0;
      shared_run <= 1'b0;
      shared_mode_live <= 1'b0;
      dot_run <= 1'b0;
      ref_out <= 2'b00;
      fixed_66_output <= 4'h0;
      shared_66_48_output <= 1'b0;
      dot_clock_48 <= 1'b0;
    end else begin
      if (~ref_phase) begin
        ref_run <= {mode_and_ref_ctrl[`BIT_REF1_EN], mode_and_ref_ctrl[`BIT_REF0_EN]} &
                   {2{~hold_others}};
      end
      if (~fixed_66_phase) begin
        fixed_run <= output_enable_ctrl_b[`BIT_FIXED_66_EN_HI:0] & {4{~hold_others}};
      end
      if (~shared_src) begin
        shared_run <= output_enable_ctrl_b[`BIT_SHARED_EN] & ~hold_others;
      end
      if (~fixed_66_phase & ~video_48_phase) begin
        shared_mode_live <= output_enable_ctrl_b[`BIT_SHARED_MODE];
      end
      if (~dot_phase) begin
        dot_run <= output_enable_ctrl_b[`BIT_DOT_CLOCK_EN] & ~hold_others;
      end
      ref_out <= {2{ref_phase}} & ref_run;
      fixed_66_output <= {4{fixed_66_phase}} & fixed_run;
      shared_66_48_output <= shared_src & shared_run;
      dot_clock_48 <= dot_phase & dot_run;
    end
  end

  // differential CPU pairs: hold and enable change only while the true leg is high
  always @(posedge clock) begin
    if (rst) begin
      cpu_hold_live <= 1'b0;
      cpu_en_live <= 4'h0;
      cpu_true_leg <= 4'h0;
      cpu_true_oe <= 4'h0;
      cpu_strong_drive <= 4'h0;
      cpu_complement_leg <= 4'h0;
      cpu_complement_oe <= 4'h0;
    end else begin
      if (cpu_phase) begin
        cpu_hold_live <= hold_cpu;
        cpu_en_live <= {output_enable_ctrl_b[`BIT_CPU_PAIR3_EN], cpu_low_pairs_enable};
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (cpu_hold_live) begin
          cpu_true_leg[i] <= 1'b1;
          cpu_true_oe[i] <= cpu_en_live[i] & ~cpu_pd_tristate[i];
          cpu_strong_drive[i] <= cpu_en_live[i] & ~cpu_pd_tristate[i];
          cpu_complement_leg[i] <= 1'b0;
          cpu_complement_oe[i] <= 1'b0;
        end else begin
          cpu_true_leg[i] <= cpu_phase;
          cpu_true_oe[i] <= cpu_en_live[i];
          cpu_strong_drive[i] <= 1'b0;
          cpu_complement_leg[i] <= ~cpu_phase;
          cpu_complement_oe[i] <= cpu_en_live[i];
        end
      end
    end
  end
endmodule // clock_output_control_powerdown

// *** sim/clock_output_control_asserts.sv ***
// concurrent checks on the output control block ports
`timescale 1ns/10ps
module clock_output_control_asserts #(
  parameter integer restart_cycles = 200,
  parameter integer cpu_drive_cycles = 60
) (
  input wire clock,
  input wire rst,
  input wire power_down_n,
  input wire ref_phase,
  input wire fixed_66_phase,
  input wire dot_phase,
  input wire video_48_phase,
  input wire [3:0] cpu_pd_tristate,
  input wire [1:0] ref_out,
  input wire [3:0] fixed_66_output,
  input wire shared_66_48_output,
  input wire dot_clock_48,
  input wire [3:0] cpu_true_leg,
  input wire [3:0] cpu_complement_leg,
  input wire [3:0] cpu_true_oe,
  input wire [3:0] cpu_strong_drive,
  input wire [3:0] cpu_complement_oe,
  input wire spread_on,
  input wire pll_stopped
);
  localparam int c_restart = restart_cycles + 16;
  localparam int c_cpu = cpu_drive_cycles + 16;
  reg [5:0] pd_low_count;
  always @(posedge clock) begin
    if (rst || power_down_n) begin
      pd_low_count <= 6'h00;
    end else if (pd_low_count != 6'h3F) begin
      pd_low_count <= pd_low_count + 6'h01;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_ref_gate; |ref_out |-> $past(ref_phase); endproperty
  a_ref_gate: assert property (p_ref_gate) else $error("ref high without source");
  property p_fixed_gate; |fixed_66_output |-> $past(fixed_66_phase); endproperty
  a_fixed_gate: assert property (p_fixed_gate) else $error("66 high without source");
  property p_dot_gate; dot_clock_48 |-> $past(dot_phase); endproperty
  a_dot_gate: assert property (p_dot_gate) else $error("dot high without source");
  property p_shared_gate; shared_66_48_output |-> $past(fixed_66_phase | video_48_phase);
  endproperty
  a_shared_gate: assert property (p_shared_gate) else $error("shared high without source");
  property p_pd_quiet;
    pd_low_count > 6'h28 |-> pll_stopped && ref_out == 2'h0 && fixed_66_output == 4'h0
      && !shared_66_48_output && !dot_clock_48;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("output running in power-down");
  property p_pd_cpu;
    pd_low_count > 6'h28 |-> cpu_complement_oe == 4'h0 && (cpu_true_oe & cpu_pd_tristate) == 4'h0
      && cpu_strong_drive == cpu_true_oe && (cpu_true_leg & cpu_true_oe) == cpu_true_oe;
  endproperty
  a_pd_cpu: assert property (p_pd_cpu) else $error("cpu legs wrong in power-down");
  property p_cpu_legs; ((cpu_true_leg ^ cpu_complement_leg) | ~cpu_true_oe) == 4'hF; endproperty
  a_cpu_legs: assert property (p_cpu_legs) else $error("cpu legs not complementary");
  property p_pd_clean; $fell(dot_clock_48) && pll_stopped |-> !$past(dot_phase); endproperty
  a_pd_clean: assert property (p_pd_clean) else $error("dot pulse cut short");
  property p_restart; $rose(power_down_n) |-> ##[1:c_restart] (!pll_stopped || !power_down_n);
  endproperty
  a_restart: assert property (p_restart) else $error("outputs late after wake");
  property p_cpu_wake;
    $rose(power_down_n) |-> ##[1:c_cpu] (cpu_strong_drive == 4'h0 || !power_down_n);
  endproperty
  a_cpu_wake: assert property (p_cpu_wake) else $error("cpu late after wake");
  property p_reset_state;
    $fell(rst) |-> ref_out == 2'h0 && cpu_true_oe == 4'h0 && !spread_on && !pll_stopped;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("outputs not cleared by reset");
endmodule // clock_output_control_asserts

bind clock_output_control_powerdown clock_output_control_asserts #(
  .restart_cycles(restart_cycles),
  .cpu_drive_cycles(cpu_drive_cycles)
) u_checker (
  .clock(clock), .rst(rst), .power_down_n(power_down_n), .ref_phase(ref_phase),
  .fixed_66_phase(fixed_66_phase), .dot_phase(dot_phase), .video_48_phase(video_48_phase),
  .cpu_pd_tristate(cpu_pd_tristate), .ref_out(ref_out), .fixed_66_output(fixed_66_output),
  .shared_66_48_output(shared_66_48_output), .dot_clock_48(dot_clock_48),
  .cpu_true_leg(cpu_true_leg), .cpu_true_oe(cpu_true_oe), .cpu_strong_drive(cpu_strong_drive),
  .cpu_complement_oe(cpu_complement_oe), .cpu_complement_leg(cpu_complement_leg),
  .spread_on(spread_on), .pll_stopped(pll_stopped)
);

// *** sim/clock_phase_source.sv ***
// synthesizer core phases feeding the gated outputs
`timescale 1ns/10ps
module clock_phase_source (
  input wire clock,
  output reg ref_phase,
  output reg fixed_66_phase,
  output reg dot_phase,
  output reg video_48_phase,
  output reg cpu_phase
);
  reg [7:0] count = 8'h00;
  initial begin
    {ref_phase, fixed_66_phase, dot_phase, video_48_phase, cpu_phase} = 5'h00;
  end
  always @(posedge clock) begin
    count <= count + 8'h01;
    ref_phase <= #1 count[3];
    fixed_66_phase <= #1 count[1];
    dot_phase <= #1 count[2];
    video_48_phase <= #1 count[2] ^ count[1];
    cpu_phase <= #1 count[1];
  end
endmodule // clock_phase_source

// *** sim/testbench.sv ***
// self-checking bench for the output control and power-down block
`timescale 1ns/10ps
`include "clock_output_control_defines.vh"
module testbench;
  localparam [3:0] rev = 4'h6; // arbitrary value
  localparam [3:0] ven = 4'h9; // arbitrary value
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg power_down_n = 1'b1;
  reg scl = 1'b1;
  reg sda_host = 1'b1;
  reg [2:0] low_en = 3'h7;
  reg [3:0] pd_tri = 4'h0;
  reg [31:0] lfsr = 32'h580D;
  reg [7:0] cur5, cur6, raw6;
  reg got = 1'b0;
  reg [31:0] got_val = 32'h0;
  reg [31:0] exp_q[$];
  integer mismatches = 0;
  integer num_checks = 0;
  integer cycles = 0;
  integer k, j;
  wire sda_wire, smb_data_oe, ref_phase, fixed_66_phase, dot_phase, video_48_phase, cpu_phase;
  wire [1:0] ref_out;
  wire [3:0] fixed_66_output, cpu_true_leg, cpu_true_oe, cpu_strong_drive, cpu_complement_oe;
  wire shared_66_48_output, dot_clock_48, video_clock_48_mode, test_clock_mode, fs_test_mode;
  wire serial_reference_pair_200, spread_on, pll_stopped, smb_data_out;
  assign sda_wire = sda_host & ~(smb_data_oe & ~smb_data_out);
  always #5 clock = ~clock;
  clock_phase_source u_phases (.clock(clock), .ref_phase(ref_phase),
    .fixed_66_phase(fixed_66_phase), .dot_phase(dot_phase),
    .video_48_phase(video_48_phase), .cpu_phase(cpu_phase));
  clock_output_control_powerdown #(.restart_cycles(200), .cpu_drive_cycles(60),
    .revision_code(rev), .vendor_code(ven)) u_dut (
    .clock(clock), .rst(rst), .power_down_n(power_down_n), .smb_clock(scl),
    .smb_data_in(sda_wire), .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe),
    .ref_phase(ref_phase), .fixed_66_phase(fixed_66_phase), .dot_phase(dot_phase),
    .video_48_phase(video_48_phase), .cpu_phase(cpu_phase), .cpu_low_pairs_enable(low_en),
    .cpu_pd_tristate(pd_tri), .ref_out(ref_out), .fixed_66_output(fixed_66_output),
    .shared_66_48_output(shared_66_48_output), .dot_clock_48(dot_clock_48),
    .cpu_true_leg(cpu_true_leg), .cpu_true_oe(cpu_true_oe), .cpu_strong_drive(cpu_strong_drive),
    .cpu_complement_leg(), .cpu_complement_oe(cpu_complement_oe),
    .video_clock_48_mode(video_clock_48_mode), .test_clock_mode(test_clock_mode),
    .fs_test_mode(fs_test_mode), .serial_reference_pair_200(serial_reference_pair_200),
    .spread_on(spread_on), .pll_stopped(pll_stopped));
  task summarize;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  task check(input [31:0] seen_v, input [31:0] exp_v);
    begin
      num_checks = num_checks + 1;
      if (seen_v !== exp_v) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen_v, exp_v);
      end
    end
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (got) begin
      check(got_val, exp_q.pop_front());
    end
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  function [31:0] next_lfsr(input [31:0] v);
    next_lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function [31:0] expect_state(input [7:0] d5, input [7:0] d6, input pd);
    reg [3:0] en;
    begin
      en = {d5[6], low_en};
      expect_state = {6'h00, pd ? 8'h00 : {d6[1:0], d5[3:0], d5[7], d5[4]},
        pd ? en & ~pd_tri : en, pd ? 4'h0 : en, pd ? en & ~pd_tri : 4'h0,
        d5[5], d6[7], d6[5], d6[4], d6[2], pd};
    end
  endfunction
  task note(input [31:0] v);
    exp_q.push_back(v);
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  task seen(input [31:0] v);
    begin
      got_val = v;
      got = 1'b1;
      tick(1);
      got = 1'b0;
    end
  endtask
  task done(input [8*16-1:0] name);
    $display("test %0s finished", name);
  endtask
  task bit_io(input b, output r);
    begin
      sda_host = b;
      tick(12);
      scl = 1'b1;
      tick(12);
      r = sda_wire;
      scl = 1'b0;
      tick(12);
    end
  endtask
  task start_cond;
    begin
      sda_host = 1'b1;
      tick(12);
      scl = 1'b1;
      tick(12);
      sda_host = 1'b0;
      tick(12);
      scl = 1'b0;
      tick(12);
    end
  endtask
  task stop_cond;
    begin
      sda_host = 1'b0;
      tick(12);
      scl = 1'b1;
      tick(12);
      sda_host = 1'b1;
      tick(12);
    end
  endtask
  task xfer(input [8:0] d, output [8:0] r);
    integer i;
    for (i = 8; i >= 0; i = i - 1) bit_io(d[i], r[i]);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg [8:0] r;
    begin
      start_cond;
      xfer({`SMB_ADDRESS_DEFAULT, 2'b01}, r);
      xfer({a, 1'b1}, r);
      xfer({d, 1'b1}, r);
      stop_cond;
    end
  endtask
  task rd(input [7:0] dev, input [7:0] a);
    reg [8:0] r;
    begin
      start_cond;
      xfer({dev, 1'b1}, r);
      if (r[0] === 1'b0) begin
        xfer({a, 1'b1}, r);
        start_cond;
        xfer({dev | 8'h01, 1'b1}, r);
        xfer(9'h1FF, r);
        seen({24'h0, r[8:1]});
      end else begin
        seen(32'h100);
      end
      stop_cond;
    end
  endtask
  task watch;
    reg [7:0] acc;
    integer i;
    begin
      acc = 8'h00;
      for (i = 0; i < 40; i = i + 1) begin
        tick(1);
        acc = acc | {ref_out, fixed_66_output, dot_clock_48, shared_66_48_output};
      end
      seen({6'h00, acc, cpu_true_oe, cpu_complement_oe, cpu_strong_drive, video_clock_48_mode,
        test_clock_mode, fs_test_mode, serial_reference_pair_200, spread_on, pll_stopped});
    end
  endtask
  task readback;
    begin
      note({24'h0, cur5});
      rd(8'hA0, `OFS_OUTPUT_ENABLE);
      note({24'h0, cur6});
      rd(8'hA0, `OFS_MODE_REF);
    end
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    tick(4);
    cur5 = `OUTPUT_ENABLE_RESET;
    cur6 = `MODE_REF_RESET;
    note(expect_state(cur5, cur6, 1'b0));
    watch;
    readback;
    done("reset values");
    for (k = 0; k < 4; k = k + 1) begin
      lfsr = next_lfsr(lfsr);
      cur5 = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : lfsr[7:0];
      raw6 = ((k == 0) ? 8'h00 : (k == 1) ? 8'hFF : lfsr[15:8]) & `MODE_REF_WRITE_MASK;
      cur6 = raw6 & `MODE_REF_WRITE_MASK;
      low_en = lfsr[18:16];
      wr(`OFS_OUTPUT_ENABLE, cur5);
      wr(`OFS_MODE_REF, raw6);
      note(expect_state(cur5, cur6, 1'b0));
      watch;
      readback;
    end
    done("control writes");
    wr(`OFS_IDENT, 8'hFF);
    note({24'h0, rev, ven});
    rd(8'hA0, `OFS_IDENT);
    note(32'h0);
    rd(8'hA0, 8'h08);
    note(32'h100);
    rd(8'hA2, `OFS_OUTPUT_ENABLE);
    done("read-only map");
    power_down_n = 1'b0;
    tick(4);
    power_down_n = 1'b1;
    note(expect_state(cur5, cur6, 1'b0));
    watch;
    done("short low pulse");
    wr(`OFS_OUTPUT_ENABLE, 8'hFF);
    wr(`OFS_MODE_REF, 8'h03);
    cur5 = 8'hFF;
    cur6 = 8'h03;
    for (j = 0; j < 2; j = j + 1) begin
      pd_tri = (j == 0) ? 4'h0 : lfsr[23:20];
      power_down_n = 1'b0;
      tick(40);
      note(expect_state(cur5, cur6, 1'b1));
      watch;
      power_down_n = 1'b1;
      for (k = 0; k < 260 && pll_stopped !== 1'b0; k = k + 1) tick(1);
      note(expect_state(cur5, cur6, 1'b0));
      watch;
    end
    done("power-down");
    summarize;
  end
endmodule // testbench
